// [include/sps_pkg.sv]
package sps_pkg;
    // Controller clock and S-curve time unit
    localparam int CLK_FREQ_HZ = 25_000_000;
    localparam int SCURVE_UNIT_MS = 1;
    localparam int TICKS_PER_MS = CLK_FREQ_HZ / 1000 * SCURVE_UNIT_MS;
    // Register byte offsets
    localparam logic [7:0] ADR_STOP = 8'h00;
    localparam logic [7:0] ADR_ALMCLR = 8'h04;
    localparam logic [7:0] ADR_DISP = 8'h08;
    localparam logic [7:0] ADR_MONSEL = 8'h0C;
    localparam logic [7:0] ADR_MON1OFS = 8'h10;
    localparam logic [7:0] ADR_MON2OFS = 8'h14;
    localparam logic [7:0] ADR_SCURVE = 8'h18;
    localparam logic [7:0] ADR_LIMUP = 8'h1C;
    localparam logic [7:0] ADR_LIMLO = 8'h20;
    localparam logic [7:0] ADR_STATUS = 8'h24;
    localparam logic [7:0] ADR_MASK = 8'h28;
    localparam logic [7:0] ADR_STATE = 8'h2C;
    localparam logic [7:0] ADR_HIST = 8'h40;
    localparam logic [7:0] ADR_MAKER = 8'h80;
    // Values after reset
    localparam logic [15:0] RST_STOP = 16'h0000;
    localparam logic [15:0] RST_ALMCLR = 16'h0000;
    localparam logic [15:0] RST_DISP = 16'h0010;
    localparam logic [15:0] RST_MONSEL = 16'h0100;
    localparam logic [15:0] RST_OFS = 16'h0000;
    localparam logic [15:0] RST_SCURVE = 16'h0000;
    localparam logic [31:0] RST_LIM = 32'h0000_0000;
    // Field codes
    localparam logic [15:0] STOP_SLOW = 16'h0001;
    localparam int CLR_LSB = 4;
    localparam logic [3:0] CLR_REQUEST = 4'h1;
    localparam logic [3:0] CLR_IDLE = 4'h0;
    localparam logic signed [15:0] OFS_MAX = 16'sh03E7;
    localparam logic signed [15:0] OFS_MIN = -16'sh03E7;
    localparam logic [7:0] ALM_PARAM_ERR = 8'h37;
    localparam int HIST_DEPTH = 6;
    localparam int MAKER_COUNT = 13;
    localparam logic [15:0] MAKER_VALUE [MAKER_COUNT] = '{
        16'h0001, 16'h0209, 16'h060A, 16'h1918, 16'h030B, 16'h0504, 16'h0102,
        16'h0000, 16'h0005, 16'h120E, 16'h0102, 16'h0000, 16'h0000};
    // Monitor item codes
    localparam logic [3:0] MON_SPEED = 4'h0;
    localparam logic [3:0] MON_TORQUE = 4'h1;
    localparam logic [3:0] MON_SPEED_ABS = 4'h2;
    localparam logic [3:0] MON_TORQUE_ABS = 4'h3;
    // Status and mask bit positions
    localparam int EV_LIMIT = 0;
    localparam int EV_PERR = 1;
    localparam int EV_ALARM = 2;
    localparam int EV_DONE = 3;
    localparam int EV_W = 4;
    // Motion completion sequence
    typedef enum logic [1:0] {
        MOT_IDLE = 2'b00,
        MOT_RUN = 2'b01,
        MOT_SHAPE = 2'b10,
        MOT_DONE = 2'b11
    } sps_motion_e;
endpackage : sps_pkg

// [logic/sps_top.sv]
// Design decisions made here: the register offsets and the Avalon-MM register port.
module sps_top #(
    // Cycles per millisecond; shorten for simulation
    parameter int TICKS_PER_MS = sps_pkg::TICKS_PER_MS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Avalon-MM register slave
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    output logic irq,
    // Position stepping
    input wire logic homing,
    input wire logic strokeEndPos,
    input wire logic strokeEndNeg,
    input wire logic signed [31:0] cmdPos,
    input wire logic incReq,
    input wire logic signed [15:0] incStep,
    output logic incGrant,
    output logic signed [15:0] incOut,
    output logic servoLock,
    output logic droopClear,
    output logic droopDrain,
    // Motion completion
    input wire logic motionStart,
    input wire logic profileDone,
    output logic motionDoneFlag,
    // Alarms and power cycle
    input wire logic alarmValid,
    input wire logic [7:0] alarmCode,
    input wire logic powerUp,
    output logic parameterErrorAlarm,
    // Display and monitors
    output logic [3:0] ampDisplayItem,
    output logic [3:0] extDisplayItem,
    input wire logic signed [15:0] speedMv,
    input wire logic signed [15:0] torqueMv,
    output logic signed [16:0] analogMonitorOne,
    output logic signed [16:0] analogMonitorTwo
);
    import sps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Parameter registers
    logic [15:0] stopPat, almClr, dispSel, monSel, monOfs1, monOfs2, scurveMs;
    logic signed [31:0] limUp, limLo;
    logic [EV_W-1:0] status, mask;
    logic [15:0] next_stopPat, next_almClr, next_dispSel, next_monSel;
    logic [15:0] next_monOfs1, next_monOfs2, next_scurveMs;
    logic signed [31:0] next_limUp, next_limLo;
    logic [EV_W-1:0] next_status, next_mask, evSet;
    logic [31:0] next_readdata, rdData;
    logic next_waitreq, next_irq, wrAck, clrPending;
    // Motion and limit state
    sps_motion_e motState, next_motState;
    logic [15:0] tickCnt, msCnt, next_tickCnt, next_msCnt;
    logic signed [31:0] target;
    logic limEnable, swOut, hwHit, limitHit, perr, next_doneFlag;
    logic next_incGrant, next_servoLock, next_droopClear, next_droopDrain;
    logic signed [15:0] next_incOut;
    // Alarm history, entry 0 is the present alarm
    logic [7:0] hist [HIST_DEPTH];
    logic [7:0] next_hist [HIST_DEPTH];
    logic histPush, perrRise;
    logic signed [16:0] next_mon1, next_mon2;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Signed clamp of an offset write
    function automatic logic [15:0] clampOfs(input logic [31:0] d);
        if ($signed(d) > $signed({{16{OFS_MAX[15]}}, OFS_MAX})) return OFS_MAX;
        if ($signed(d) < $signed({{16{OFS_MIN[15]}}, OFS_MIN})) return OFS_MIN;
        return d[15:0];
    endfunction : clampOfs
    // Source of one monitor channel by item digit
    function automatic logic signed [16:0] monSrc(input logic [3:0] item,
            input logic signed [15:0] spd, input logic signed [15:0] trq);
        logic signed [15:0] v;
        v = 16'sh0000;
        if (item == MON_SPEED) v = spd;
        else if (item == MON_TORQUE) v = trq;
        else if (item == MON_SPEED_ABS) v = spd[15] ? -spd : spd;
        else if (item == MON_TORQUE_ABS) v = trq[15] ? -trq : trq;
        return {v[15], v};
    endfunction : monSrc
    ////////////////////////////////////////////////////////////////////////////
    // Read decode; maker words come from constants only
    always_comb begin
        rdData = 32'h0000_0000;
        if (avsAddress == ADR_STOP) rdData = {16'h0000, stopPat};
        else if (avsAddress == ADR_ALMCLR) rdData = {16'h0000, almClr};
        else if (avsAddress == ADR_DISP) rdData = {16'h0000, dispSel};
        else if (avsAddress == ADR_MONSEL) rdData = {16'h0000, monSel};
        else if (avsAddress == ADR_MON1OFS) rdData = {{16{monOfs1[15]}}, monOfs1};
        else if (avsAddress == ADR_MON2OFS) rdData = {{16{monOfs2[15]}}, monOfs2};
        else if (avsAddress == ADR_SCURVE) rdData = {16'h0000, scurveMs};
        else if (avsAddress == ADR_LIMUP) rdData = limUp;
        else if (avsAddress == ADR_LIMLO) rdData = limLo;
        else if (avsAddress == ADR_STATUS) rdData = {28'h0000000, status};
        else if (avsAddress == ADR_MASK) rdData = {28'h0000000, mask};
        else if (avsAddress == ADR_STATE)
            rdData = {24'h000000, motState, servoLock, droopDrain, homing,
                parameterErrorAlarm, motionDoneFlag, clrPending};
        else if (avsAddress >= ADR_HIST && avsAddress < ADR_HIST + 8'(4 * HIST_DEPTH))
            rdData = {24'h000000, hist[3'((avsAddress - ADR_HIST) >> 2)]};
        else if (avsAddress >= ADR_MAKER && avsAddress < ADR_MAKER + 8'(4 * MAKER_COUNT))
            rdData = {16'h0000, MAKER_VALUE[4'((avsAddress - ADR_MAKER) >> 2)]};
    end
    assign wrAck = avsWrite && !avsWaitrequest;
    assign clrPending = almClr[CLR_LSB+:4] == CLR_REQUEST;
    // Bus answer one cycle after the request; register writes land one edge later, when wrAck is high
    always_comb begin
        next_waitreq = !((avsRead || avsWrite) && avsWaitrequest);
        next_readdata = (avsRead && avsWaitrequest) ? rdData : avsReaddata;
        next_stopPat = stopPat;
        next_almClr = almClr;
        next_dispSel = dispSel;
        next_monSel = monSel;
        next_monOfs1 = monOfs1;
        next_monOfs2 = monOfs2;
        next_scurveMs = scurveMs;
        next_limUp = limUp;
        next_limLo = limLo;
        next_mask = mask;
        next_status = status;
        if (wrAck) begin
            // Maker and history words have no write path
            if (avsAddress == ADR_STOP) next_stopPat = avsWritedata[15:0];
            else if (avsAddress == ADR_ALMCLR) next_almClr = avsWritedata[15:0];
            else if (avsAddress == ADR_DISP) next_dispSel = avsWritedata[15:0];
            else if (avsAddress == ADR_MONSEL) next_monSel = avsWritedata[15:0];
            else if (avsAddress == ADR_MON1OFS) next_monOfs1 = clampOfs(avsWritedata);
            else if (avsAddress == ADR_MON2OFS) next_monOfs2 = clampOfs(avsWritedata);
            else if (avsAddress == ADR_SCURVE) next_scurveMs = avsWritedata[15:0];
            else if (avsAddress == ADR_LIMUP) next_limUp = avsWritedata;
            else if (avsAddress == ADR_LIMLO) next_limLo = avsWritedata;
            else if (avsAddress == ADR_STATUS) next_status = status & ~avsWritedata[EV_W-1:0];
            else if (avsAddress == ADR_MASK) next_mask = avsWritedata[EV_W-1:0];
        end
        // Request digit drops back once the power-up clear has run
        if (powerUp && clrPending) next_almClr[CLR_LSB+:4] = CLR_IDLE;
        // Event wins over a write-one clear in the same cycle
        next_status = next_status | evSet;
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            avsWaitrequest <= 1'b1;
            avsReaddata <= 32'h0000_0000;
            irq <= 1'b0;
            stopPat <= RST_STOP;
            almClr <= RST_ALMCLR;
            dispSel <= RST_DISP;
            monSel <= RST_MONSEL;
            monOfs1 <= RST_OFS;
            monOfs2 <= RST_OFS;
            scurveMs <= RST_SCURVE;
            limUp <= RST_LIM;
            limLo <= RST_LIM;
            status <= '0;
            mask <= '0;
        end else begin
            avsWaitrequest <= next_waitreq;
            avsReaddata <= next_readdata;
            irq <= next_irq;
            stopPat <= next_stopPat;
            almClr <= next_almClr;
            dispSel <= next_dispSel;
            monSel <= next_monSel;
            monOfs1 <= next_monOfs1;
            monOfs2 <= next_monOfs2;
            scurveMs <= next_scurveMs;
            limUp <= next_limUp;
            limLo <= next_limLo;
            status <= next_status;
            mask <= next_mask;
        end
    end
    AST_BUS_ANSWER: assert property ((avsRead || avsWrite) && avsWaitrequest
        |=> !avsWaitrequest ##1 avsWaitrequest) else $error("bus answer late");
    AST_OFS_RANGE: assert property ($signed(monOfs1) <= OFS_MAX
        && $signed(monOfs1) >= OFS_MIN && $signed(monOfs2) <= OFS_MAX
        && $signed(monOfs2) >= OFS_MIN) else $error("offset out of range");
    AST_CLR_DIGIT: assert property (powerUp && clrPending && !wrAck
        |=> almClr[CLR_LSB+:4] == CLR_IDLE && hist[0] == 8'h00) else $error("no clear");
    ////////////////////////////////////////////////////////////////////////////
    // Limit check on the target of each step, signed
    always_comb begin
        target = cmdPos + 32'(incStep);
        perr = limUp < limLo;
        limEnable = !homing && (limUp != limLo) && !perr;
        swOut = limEnable && (target > limUp || target < limLo);
        hwHit = (strokeEndPos && !incStep[15] && incStep != 16'sh0000)
            || (strokeEndNeg && incStep[15]);
        limitHit = incReq && (swOut || hwHit);
        next_incGrant = incReq && !limitHit;
        next_incOut = next_incGrant ? incStep : 16'sh0000;
        // Lock holds until a step that stays in range
        next_servoLock = limitHit ? 1'b1 : (incReq ? 1'b0 : servoLock);
        // Sudden stop resets droop, slow stop drains it
        next_droopClear = limitHit && stopPat != STOP_SLOW;
        next_droopDrain = limitHit ? (stopPat == STOP_SLOW)
            : (incReq ? 1'b0 : droopDrain);
        // Monitor channels with offsets added
        next_mon1 = monSrc(monSel[3:0], speedMv, torqueMv) + {monOfs1[15], monOfs1};
        next_mon2 = monSrc(monSel[11:8], speedMv, torqueMv) + {monOfs2[15], monOfs2};
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            incGrant <= 1'b0;
            incOut <= 16'sh0000;
            servoLock <= 1'b0;
            droopClear <= 1'b0;
            droopDrain <= 1'b0;
            parameterErrorAlarm <= 1'b0;
            ampDisplayItem <= RST_DISP[3:0];
            extDisplayItem <= RST_DISP[7:4];
            analogMonitorOne <= 17'sh00000;
            analogMonitorTwo <= 17'sh00000;
        end else begin
            incGrant <= next_incGrant;
            incOut <= next_incOut;
            servoLock <= next_servoLock;
            droopClear <= next_droopClear;
            droopDrain <= next_droopDrain;
            parameterErrorAlarm <= perr;
            ampDisplayItem <= dispSel[3:0];
            extDisplayItem <= dispSel[7:4];
            analogMonitorOne <= next_mon1;
            analogMonitorTwo <= next_mon2;
        end
    end
    AST_DISPLAY: assert property ($past(srst) |-> ampDisplayItem == RST_DISP[3:0]
        && extDisplayItem == RST_DISP[7:4]) else $error("power-on display wrong");
    // A held out-of-range request may pulse the clear again; only a lone hit must end it
    AST_SUDDEN: assert property (limitHit && stopPat != STOP_SLOW
        |=> droopClear && !droopDrain ##1 (!droopClear || $past(limitHit)))
        else $error("no sudden stop");
    AST_SLOW: assert property (limitHit && stopPat == STOP_SLOW
        |=> droopDrain && !droopClear) else $error("no slow stop");
    AST_LOCK: assert property (limitHit |=> servoLock && !incGrant && incOut == 16'sh0000)
        else $error("limit did not lock");
    AST_HOMING: assert property (homing && incReq && !hwHit |=> incGrant)
        else $error("limit active in home return");
    AST_EQUAL: assert property (limUp == limLo && incReq && !hwHit |=> incGrant)
        else $error("equal limits still checked");
    AST_PERR: assert property (limUp < limLo |=> parameterErrorAlarm)
        else $error("parameter error missing");
    COV_SLOW: cover property (limitHit && stopPat == STOP_SLOW ##1 droopDrain);
    COV_PERR: cover property ($rose(parameterErrorAlarm));
    ////////////////////////////////////////////////////////////////////////////
    // Done flag; S-curve adds exactly scurveMs milliseconds
    always_comb begin
        next_motState = motState;
        next_tickCnt = tickCnt;
        next_msCnt = msCnt;
        case (motState)
            MOT_IDLE, MOT_DONE: begin
                if (motionStart) next_motState = MOT_RUN;
            end
            MOT_RUN: begin
                next_tickCnt = 16'h0000;
                next_msCnt = 16'h0000;
                if (profileDone)
                    next_motState = (scurveMs == 16'h0000) ? MOT_DONE : MOT_SHAPE;
            end
            MOT_SHAPE: begin
                next_tickCnt = tickCnt + 16'h0001;
                if (tickCnt == 16'(TICKS_PER_MS - 1)) begin
                    next_tickCnt = 16'h0000;
                    next_msCnt = msCnt + 16'h0001;
                    if (msCnt + 16'h0001 == scurveMs) next_motState = MOT_DONE;
                end
            end
            default: next_motState = MOT_IDLE;
        endcase
        next_doneFlag = next_motState == MOT_DONE;
        // Hardware events feeding the sticky status
        perrRise = perr && !parameterErrorAlarm;
        histPush = alarmValid || perrRise;
        evSet = {next_doneFlag && !motionDoneFlag, histPush, perr, limitHit};
        // History shifts on each new alarm; clear only at power-up
        for (int i = 0; i < HIST_DEPTH; i++) next_hist[i] = hist[i];
        if (powerUp && clrPending) begin
            for (int i = 0; i < HIST_DEPTH; i++) next_hist[i] = 8'h00;
        end else if (histPush) begin
            for (int i = HIST_DEPTH - 1; i > 0; i--) next_hist[i] = hist[i-1];
            next_hist[0] = alarmValid ? alarmCode : ALM_PARAM_ERR;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            motState <= MOT_IDLE;
            tickCnt <= 16'h0000;
            msCnt <= 16'h0000;
            motionDoneFlag <= 1'b0;
            for (int i = 0; i < HIST_DEPTH; i++) hist[i] <= 8'h00;
        end else begin
            motState <= next_motState;
            tickCnt <= next_tickCnt;
            msCnt <= next_msCnt;
            motionDoneFlag <= next_doneFlag;
            for (int i = 0; i < HIST_DEPTH; i++) hist[i] <= next_hist[i];
        end
    end
    AST_SDELAY: assert property ($rose(motionDoneFlag) |-> ($past(motState) == MOT_RUN
        && scurveMs == 16'h0000) || ($past(msCnt) + 16'h0001 == scurveMs))
        else $error("done delay wrong");
    AST_NO_EARLY_CLR: assert property (wrAck && avsAddress == ADR_ALMCLR && !powerUp
        && !histPush |=> hist[0] == $past(hist[0])) else $error("history cleared early");
    AST_HIST_SHIFT: assert property (alarmValid && !powerUp |=> hist[0] == $past(alarmCode)
        && hist[1] == $past(hist[0])) else $error("history not shifted");
    COV_SCURVE: cover property (motState == MOT_SHAPE ##1 motionDoneFlag);
    COV_CLEAR: cover property (powerUp && clrPending);
endmodule : sps_top

// [verif/sps_motor_model.sv]
// Far side: motor, encoder and limit switches
module sps_motor_model #(
    // Switch positions, in command units
    parameter int STROKE = 30000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Granted steps from the controller
    input wire logic incGrant,
    input wire logic signed [15:0] incOut,
    // Feedback to the controller
    output logic signed [31:0] cmdPos,
    output logic signed [15:0] speedMv,
    output logic signed [15:0] torqueMv,
    output logic strokeEndPos,
    output logic strokeEndNeg
);
    timeunit 1ns;
    timeprecision 1ps;
    // Position integrates granted steps; torque opposes speed so that one is negative
    always_ff @(posedge clk) begin
        if (srst) begin
            cmdPos <= '0;
            speedMv <= '0;
            torqueMv <= '0;
        end else if (incGrant) begin
            cmdPos <= cmdPos + incOut;
            speedMv <= incOut;
            torqueMv <= -incOut;
        end
    end
    // Switches close only past the travel ends
    assign strokeEndPos = cmdPos > STROKE;
    assign strokeEndNeg = cmdPos < -STROKE;
endmodule : sps_motor_model

// [verif/servo_param_supervision_bench.sv]
module servo_param_supervision_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sps_pkg::*;
    localparam int TICKS = 4; // Short millisecond keeps S-curve waits brief
    logic clk, srst, avsRead, avsWrite, irq, avsWaitrequest, homing, incReq, incGrant;
    logic [7:0] avsAddress, alarmCode;
    logic [31:0] avsWritedata, avsReaddata, rnd;
    logic strokeEndPos, strokeEndNeg, servoLock, droopClear, droopDrain, parameterErrorAlarm;
    logic motionStart, profileDone, motionDoneFlag, alarmValid, powerUp;
    logic signed [31:0] cmdPos;
    logic signed [15:0] incStep, incOut, speedMv, torqueMv;
    logic signed [16:0] analogMonitorOne, analogMonitorTwo;
    logic [3:0] ampDisplayItem, extDisplayItem;
    logic [31:0] expQ [$]; // Expected read data, oldest first
    int miscompares = 0;
    int checksDone = 0;
    int cyc = 0;
    int n;
    sps_top #(.TICKS_PER_MS(TICKS)) uut (.clk(clk), .srst(srst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .irq(irq),
        .homing(homing), .strokeEndPos(strokeEndPos), .strokeEndNeg(strokeEndNeg),
        .cmdPos(cmdPos), .incReq(incReq), .incStep(incStep), .incGrant(incGrant),
        .incOut(incOut), .servoLock(servoLock), .droopClear(droopClear),
        .droopDrain(droopDrain), .motionStart(motionStart), .profileDone(profileDone),
        .motionDoneFlag(motionDoneFlag), .alarmValid(alarmValid), .alarmCode(alarmCode),
        .powerUp(powerUp), .parameterErrorAlarm(parameterErrorAlarm),
        .ampDisplayItem(ampDisplayItem), .extDisplayItem(extDisplayItem),
        .speedMv(speedMv), .torqueMv(torqueMv), .analogMonitorOne(analogMonitorOne),
        .analogMonitorTwo(analogMonitorTwo));
    sps_motor_model motor (.clk(clk), .srst(srst), .incGrant(incGrant), .incOut(incOut),
        .cmdPos(cmdPos), .speedMv(speedMv), .torqueMv(torqueMv),
        .strokeEndPos(strokeEndPos), .strokeEndNeg(strokeEndNeg));
    ////////////////////////////////////////////////////////////////////////////////
    // Comparison and verdict
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic results;
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////////
    // Drivers; every wait is cut short by the cycle ceiling
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= d;
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        expQ.push_back(exp);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // One-cycle pulse: 0 start, 1 profile end, 2 alarm, 3 power cycle
    task automatic kick(input int k);
        @(posedge clk);
        {powerUp, alarmValid, profileDone, motionStart} <= 4'(1 << k);
        @(posedge clk);
        {powerUp, alarmValid, profileDone, motionStart} <= 4'h0;
    endtask : kick
    task automatic step(input logic signed [15:0] s, input logic g);
        @(posedge clk);
        incStep <= s;
        incReq <= 1'b1;
        @(posedge clk);
        incReq <= 1'b0;
        @(negedge clk);
        check("incGrant", incGrant, g);
        check("incOut", incOut, g ? s : 16'sh0);
        check("servoLock", servoLock, !g);
    endtask : step
    task automatic motion(input int s);
        bus(1'b1, ADR_SCURVE, s);
        kick(0);
        @(negedge clk);
        check("doneDrop", motionDoneFlag, 1'b0);
        kick(1);
        n = 0;
        @(negedge clk);
        while (motionDoneFlag !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check("doneDelay", n, s * TICKS);
    endtask : motion
    // Monitor item by code: speed, torque and their magnitudes
    function automatic logic signed [16:0] pick(input int c);
        logic signed [16:0] v;
        v = c[0] ? torqueMv : speedMv;
        if (c[1] && v < 0) v = -v;
        return v;
    endfunction : pick
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    ////////////////////////////////////////////////////////////////////////////////
    // Read answers are compared where they stand, against the oldest note
    always @(posedge clk) begin
        cyc++;
        if (avsRead && avsWaitrequest === 1'b0) check("readdata", avsReaddata, expQ.pop_front());
        if (cyc == 6000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {srst, homing, incReq, avsRead, avsWrite} = 5'b10000;
        {powerUp, alarmValid, profileDone, motionStart} = 4'h0;
        {avsAddress, alarmCode, incStep, avsWritedata} = '0;
        rnd = 32'h67008B2F;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        check("ampDisplay", ampDisplayItem, 4'h0);
        check("extDisplay", extDisplayItem, 4'h1);
        rd(ADR_DISP, 32'h10);
        rd(ADR_MONSEL, 32'h100);
        bus(1'b1, ADR_DISP, 32'h23);
        // Display items follow the register one clock after the write lands
        repeat (2) @(negedge clk);
        check("ampDisplay", ampDisplayItem, 4'h3);
        check("extDisplay", extDisplayItem, 4'h2);
        bus(1'b1, ADR_MAKER, 32'hFFFF); // Writes to device-owned words must not stick
        for (int i = 0; i < MAKER_COUNT; i++) rd(ADR_MAKER + 8'(4 * i), 32'(MAKER_VALUE[i]));
        rd(8'h30, 32'h0);
        $display("test registers done");
        bus(1'b1, ADR_LIMUP, 32'd100);
        bus(1'b1, ADR_LIMLO, -32'sd100);
        bus(1'b1, ADR_STATUS, 32'hF);
        bus(1'b1, ADR_MASK, 32'h1);
        step(16'sd50, 1'b1);
        step(16'sd60, 1'b0);
        check("droopClear", droopClear, 1'b1);
        @(negedge clk);
        check("droopClear", droopClear, 1'b0);
        check("irq", irq, 1'b1);
        rd(ADR_STATUS, 32'h1);
        bus(1'b1, ADR_STATUS, 32'h1);
        repeat (2) @(negedge clk);
        check("irq", irq, 1'b0);
        bus(1'b1, ADR_STOP, {16'h0, STOP_SLOW});
        step(16'sd70, 1'b0);
        check("droopDrain", droopDrain, 1'b1);
        check("droopClear", droopClear, 1'b0);
        step(-16'sd10, 1'b1);
        check("droopDrain", droopDrain, 1'b0);
        @(posedge clk) homing <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            step(16'(rnd[9:0]) + 16'sd200, 1'b1);
        end
        @(posedge clk) homing <= 1'b0;
        bus(1'b1, ADR_LIMUP, 32'h0);
        bus(1'b1, ADR_LIMLO, 32'h0);
        step(16'sd500, 1'b1);
        $display("test limits done");
        bus(1'b1, ADR_MON1OFS, 32'd2000);
        bus(1'b1, ADR_MON2OFS, -32'sd2000);
        rd(ADR_MON1OFS, 32'h3E7);
        rd(ADR_MON2OFS, 32'hFFFFFC19);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, ADR_MONSEL, 32'((c << 8) | c));
            repeat (2) @(negedge clk);
            check("monitorOne", analogMonitorOne, pick(c) + 17'sd999);
            check("monitorTwo", analogMonitorTwo, pick(c) - 17'sd999);
        end
        $display("test monitors done");
        motion(0);
        motion(2);
        $display("test motion done");
        for (int i = 1; i <= 7; i++) begin
            alarmCode <= 8'(8'hA0 + i);
            kick(2);
        end
        for (int i = 0; i < HIST_DEPTH; i++) rd(ADR_HIST + 8'(4 * i), 32'(8'hA7 - i));
        bus(1'b1, ADR_ALMCLR, 32'h10);
        rd(ADR_HIST, 32'hA7);
        kick(3);
        rd(ADR_ALMCLR, 32'h0);
        rd(ADR_HIST, 32'h0);
        $display("test history done");
        bus(1'b1, ADR_LIMLO, 32'd5);
        bus(1'b1, ADR_LIMUP, -32'sd5);
        repeat (2) @(negedge clk);
        check("paramError", parameterErrorAlarm, 1'b1);
        rd(ADR_HIST, 32'h37);
        $display("test parameter error done");
        results();
    end
endmodule : servo_param_supervision_bench
